// ===== rtl/analog_peripheral_control_regs.v
// Purpose: Control registers for gate drivers, test pin routing, role and feedback mux
// Assumes: AXI4-Lite slave on aclk, synchronous active-low reset
// Notes: Analog behaviour is represented by the control levels driven out
// Notes on behaviour
// RQ1 - Enable bit seven drives the primary gate output enable.
// RQ2 - Enable bit six drives the secondary gate output enable independently.
// RQ3 - Bit five set bypasses primary dead time, clear applies it.
// RQ4 - Bit four set bypasses secondary dead time, clear applies it.
// RQ5 - Unimplemented bits read zero and ignore writes.
// RQ6 - Bit two enables the weak pull-up on the secondary sense input.
// RQ7 - Bit one applies open-loop fixed PWM steering to the primary driver.
// RQ8 - Bit zero applies open-loop fixed PWM steering to the secondary driver.
// RQ9 - Both steering bits set: primary wins, secondary steering suppressed.
// RQ10 - Secondary steering pulses only while overvoltage protection is active.
// RQ11 - Digital test enable connects the digital test mux to the test pin.
// RQ12 - Analog test enable connects the analog mux to the test pin.
// RQ13 - Both test enables set: the digital mux owns the pin.
// RQ14 - Analog enable clear routes the analog test signal to the converter.
// RQ15 - Three-bit select picks one of seven digital test signals; code seven unused.
// RQ16 - Bit three selects the higher gate undervoltage level; resets clear.
// RQ17 - Bit one disables the error amplifier, parking its output low.
// RQ18 - Role field: stand-alone, main, secondary; code three reserved.
// RQ19 - Main role routes second reference to GPIO; stand-alone leaves it unconnected.
// RQ20 - Feedback bit selects internal resistor when clear, external pin when set.
// RQ21 - Implemented bits are read/write, reset at power-on, effective next edge.
`timescale 1ns/1ps
`default_nettype none
`include "periph_ctrl_defines.vh"
module analog_peripheral_control_regs (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire desat_comparator_out,
    input wire pulse_after_monostable,
    input wire oscillator_pwm,
    input wire timer_period_match,
    input wire overvoltage_comparator,
    input wire switching_frequency_out,
    input wire secondary_on_pulse,
    input wire overvoltage_protection_active,
    output reg primary_gate_output_enable,
    output reg secondary_gate_output_enable,
    output reg primary_deadtime_bypass,
    output reg secondary_deadtime_bypass,
    output reg sense_pullup_enable,
    output reg primary_steering_active,
    output reg secondary_steering_active,
    output reg shared_test_pin,
    output reg shared_test_pin_oe,
    output reg analog_test_to_pin,
    output reg analog_test_to_converter,
    output reg gate_uvlo_level_select,
    output reg error_amp_disable,
    output reg [1:0] role_config,
    output reg second_reference_to_gpio,
    output reg feedback_path_select
);
    reg [7:0] gate_drive_enable_ctrl;
    reg [7:0] analog_block_enable_ctrl;
    reg [7:0] role_and_feedback_mux_ctrl;

    // Write address and data are latched separately so either may come first
    reg aw_held;
    reg w_held;
    reg [3:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire do_write;
    wire digital_selected;

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    function addr_known;
        input [3:0] addr;
        begin
            addr_known = (addr == `GATE_DRIVE_ENABLE_CTRL_ADDR) ||
                (addr == `ANALOG_BLOCK_ENABLE_CTRL_ADDR) ||
                (addr == `ROLE_AND_FEEDBACK_MUX_CTRL_ADDR);
        end
    endfunction

    // Byte lane 0 carries the whole register; masking keeps unused bits at zero
    function [7:0] merge_byte;
        input [7:0] old_value;
        input [7:0] new_value;
        input lane;
        input [7:0] mask;
        begin
            merge_byte = lane ? (new_value & mask) : old_value;
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_known(aw_addr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            gate_drive_enable_ctrl <= `GATE_DRIVE_ENABLE_CTRL_RESET; // RQ21
            analog_block_enable_ctrl <= `ANALOG_BLOCK_ENABLE_CTRL_RESET; // RQ16
            role_and_feedback_mux_ctrl <= `ROLE_AND_FEEDBACK_MUX_CTRL_RESET;
        end else if (do_write) begin
            if (aw_addr == `GATE_DRIVE_ENABLE_CTRL_ADDR) begin
                gate_drive_enable_ctrl <= merge_byte(gate_drive_enable_ctrl, w_data[7:0],
                    w_strb[0], `GATE_DRIVE_ENABLE_CTRL_MASK); // RQ5
            end
            if (aw_addr == `ANALOG_BLOCK_ENABLE_CTRL_ADDR) begin
                analog_block_enable_ctrl <= merge_byte(analog_block_enable_ctrl, w_data[7:0],
                    w_strb[0], `ANALOG_BLOCK_ENABLE_CTRL_MASK); // RQ5
            end
            if (aw_addr == `ROLE_AND_FEEDBACK_MUX_CTRL_ADDR) begin
                // Reserved role code is stored as written; software must avoid it
                role_and_feedback_mux_ctrl <= merge_byte(role_and_feedback_mux_ctrl,
                    w_data[7:0], w_strb[0], `ROLE_AND_FEEDBACK_MUX_CTRL_MASK); // RQ5
            end
        end
    end

    // Read channel: one cycle to accept, data the cycle after
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AXI_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= addr_known(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
                case (s_axi_araddr)
                    `GATE_DRIVE_ENABLE_CTRL_ADDR: begin
                        s_axi_rdata <= {24'h000000, gate_drive_enable_ctrl}; // RQ21
                    end
                    `ANALOG_BLOCK_ENABLE_CTRL_ADDR: begin
                        s_axi_rdata <= {24'h000000, analog_block_enable_ctrl};
                    end
                    `ROLE_AND_FEEDBACK_MUX_CTRL_ADDR: begin
                        s_axi_rdata <= {24'h000000, role_and_feedback_mux_ctrl};
                    end
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    test_signal_select u_test_signal_select (
        .aclk(aclk),
        .aresetn(aresetn),
        .select(analog_block_enable_ctrl[`DIGITAL_TEST_SELECT_MSB:`DIGITAL_TEST_SELECT_LSB]),
        .sources({secondary_on_pulse, switching_frequency_out, overvoltage_comparator,
            timer_period_match, oscillator_pwm, pulse_after_monostable,
            desat_comparator_out}), // RQ15
        .selected(digital_selected)
    );

    // Control outputs follow the registers one edge later; shared_test_pin lags by two, through the test mux flop
    always @(posedge aclk) begin
        if (!aresetn) begin
            primary_gate_output_enable <= 1'b0;
            secondary_gate_output_enable <= 1'b0;
            primary_deadtime_bypass <= 1'b0;
            secondary_deadtime_bypass <= 1'b0;
            sense_pullup_enable <= 1'b0;
            primary_steering_active <= 1'b0;
            secondary_steering_active <= 1'b0;
            shared_test_pin <= 1'b0;
            shared_test_pin_oe <= 1'b0;
            analog_test_to_pin <= 1'b0;
            analog_test_to_converter <= 1'b0;
            gate_uvlo_level_select <= 1'b0;
            error_amp_disable <= 1'b0;
            role_config <= `ROLE_STAND_ALONE;
            second_reference_to_gpio <= 1'b0;
            feedback_path_select <= 1'b0;
        end else begin
            primary_gate_output_enable <=
                gate_drive_enable_ctrl[`PRIMARY_DRIVER_ENABLE_BIT]; // RQ1
            secondary_gate_output_enable <=
                gate_drive_enable_ctrl[`SECONDARY_DRIVER_ENABLE_BIT]; // RQ2
            primary_deadtime_bypass <=
                gate_drive_enable_ctrl[`PRIMARY_DEADTIME_BYPASS_BIT]; // RQ3
            secondary_deadtime_bypass <=
                gate_drive_enable_ctrl[`SECONDARY_DEADTIME_BYPASS_BIT]; // RQ4
            sense_pullup_enable <= gate_drive_enable_ctrl[`SENSE_PULLUP_ENABLE_BIT]; // RQ6
            primary_steering_active <=
                gate_drive_enable_ctrl[`PRIMARY_STEERING_ENABLE_BIT]; // RQ7
            // Primary steering dominates, and secondary needs OV protection
            secondary_steering_active <=
                gate_drive_enable_ctrl[`SECONDARY_STEERING_ENABLE_BIT] &&
                !gate_drive_enable_ctrl[`PRIMARY_STEERING_ENABLE_BIT] && // RQ9
                overvoltage_protection_active; // RQ10
            shared_test_pin <= digital_selected;
            shared_test_pin_oe <= analog_block_enable_ctrl[`DIGITAL_TEST_OUT_ENABLE_BIT]; // RQ11
            analog_test_to_pin <= analog_block_enable_ctrl[`ANALOG_TEST_OUT_ENABLE_BIT] &&
                !analog_block_enable_ctrl[`DIGITAL_TEST_OUT_ENABLE_BIT]; // RQ12 RQ13
            analog_test_to_converter <=
                !analog_block_enable_ctrl[`ANALOG_TEST_OUT_ENABLE_BIT]; // RQ14
            gate_uvlo_level_select <= analog_block_enable_ctrl[`GATE_UVLO_LEVEL_SELECT_BIT]; // RQ16
            error_amp_disable <= analog_block_enable_ctrl[`ERROR_AMP_DISABLE_BIT]; // RQ17
            role_config <= role_and_feedback_mux_ctrl[`ROLE_CONFIG_MSB:`ROLE_CONFIG_LSB]; // RQ18
            second_reference_to_gpio <=
                (role_and_feedback_mux_ctrl[`ROLE_CONFIG_MSB:`ROLE_CONFIG_LSB] ==
                `ROLE_MAIN); // RQ19
            feedback_path_select <= role_and_feedback_mux_ctrl[`FEEDBACK_PATH_SELECT_BIT]; // RQ20
        end
    end
endmodule
`default_nettype wire

// ===== rtl/periph_ctrl_defines.vh
// Purpose: Offsets, field positions, reset values for the analog peripheral control bank
// Assumes: AXI4-Lite, 32-bit data, registers in low 8 bits
// Notes: Upper bits of each word read as zero
`ifndef PERIPH_CTRL_DEFINES_VH
`define PERIPH_CTRL_DEFINES_VH

`define GATE_DRIVE_ENABLE_CTRL_ADDR 4'h0
`define ANALOG_BLOCK_ENABLE_CTRL_ADDR 4'h4
`define ROLE_AND_FEEDBACK_MUX_CTRL_ADDR 4'h8

`define GATE_DRIVE_ENABLE_CTRL_RESET 8'h04
`define ANALOG_BLOCK_ENABLE_CTRL_RESET 8'h00
`define ROLE_AND_FEEDBACK_MUX_CTRL_RESET 8'h00

`define GATE_DRIVE_ENABLE_CTRL_MASK 8'hf7
`define ANALOG_BLOCK_ENABLE_CTRL_MASK 8'hfb
`define ROLE_AND_FEEDBACK_MUX_CTRL_MASK 8'he0

`define PRIMARY_DRIVER_ENABLE_BIT 7
`define SECONDARY_DRIVER_ENABLE_BIT 6
`define PRIMARY_DEADTIME_BYPASS_BIT 5
`define SECONDARY_DEADTIME_BYPASS_BIT 4
`define SENSE_PULLUP_ENABLE_BIT 2
`define PRIMARY_STEERING_ENABLE_BIT 1
`define SECONDARY_STEERING_ENABLE_BIT 0

`define DIGITAL_TEST_OUT_ENABLE_BIT 7
`define DIGITAL_TEST_SELECT_MSB 6
`define DIGITAL_TEST_SELECT_LSB 4
`define GATE_UVLO_LEVEL_SELECT_BIT 3
`define ERROR_AMP_DISABLE_BIT 1
`define ANALOG_TEST_OUT_ENABLE_BIT 0

`define ROLE_CONFIG_MSB 7
`define ROLE_CONFIG_LSB 6
`define FEEDBACK_PATH_SELECT_BIT 5

`define ROLE_STAND_ALONE 2'h0
`define ROLE_MAIN 2'h1
`define ROLE_SECONDARY 2'h2

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ===== rtl/test_signal_select.v
// Purpose: Digital test multiplexer choosing one internal signal by a 3-bit code
// Assumes: Inputs synchronous to aclk
// Notes: Output is registered so the pin path starts at a flip-flop
`timescale 1ns/1ps
`default_nettype none
module test_signal_select (
    input wire aclk,
    input wire aresetn,
    input wire [2:0] select,
    input wire [6:0] sources,
    output reg selected
);
    always @(posedge aclk) begin
        if (!aresetn) begin
            selected <= 1'b0;
        end else if (select == 3'h7) begin
            // Unimplemented code drives a quiet low
            selected <= 1'b0;
        end else begin
            selected <= sources[select];
        end
    end
endmodule
`default_nettype wire

// ===== bench/periph_ctrl_checker.sv
// Purpose: Port assertions for the analog peripheral control bank
// Assumes: One clock, synchronous active-low reset
// Notes: Attached to every instance of the bank by bind
`timescale 1ns/1ps
`default_nettype none
`include "periph_ctrl_defines.vh"
module periph_ctrl_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic primary_steering_active,
    input wire logic secondary_steering_active,
    input wire logic shared_test_pin_oe,
    input wire logic analog_test_to_pin,
    input wire logic analog_test_to_converter,
    input wire logic [1:0] role_config,
    input wire logic second_reference_to_gpio
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_read_taken;
        s_axi_arready ##1 s_axi_rvalid;
    endsequence
    sequence s_read_waiting;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    // Primary steering dominates, so both active at once is never legal
    property p_steer; secondary_steering_active |-> !primary_steering_active; endproperty
    a_steer: assert property (p_steer) else $error("both steering outputs active");
    property p_pin; analog_test_to_pin |-> !shared_test_pin_oe; endproperty
    a_pin: assert property (p_pin) else $error("analog path on pin while digital owns it");
    property p_route; analog_test_to_converter |-> !analog_test_to_pin; endproperty
    a_route: assert property (p_route) else $error("analog signal on pin and converter");
    property p_gpio; second_reference_to_gpio == (role_config == `ROLE_MAIN); endproperty
    a_gpio: assert property (p_gpio) else $error("second reference routing wrong");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped early");
    property p_rhold; s_read_waiting |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_rupper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_rupper: assert property (p_rupper) else $error("upper read bits not zero");
    property p_rans; s_axi_arready |-> s_read_taken; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
endmodule
bind analog_peripheral_control_regs periph_ctrl_checker chk (.aclk, .aresetn, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready,
    .primary_steering_active, .secondary_steering_active, .shared_test_pin_oe,
    .analog_test_to_pin, .analog_test_to_converter, .role_config, .second_reference_to_gpio);
`default_nettype wire

// ===== bench/tb_analog_peripheral_control_regs.sv
// Purpose: Self-checking bench for the analog peripheral control bank
// Assumes: AXI4-Lite master tasks on the 100 ns clock
// Notes: Test sources are driven one-hot, then inverted
`timescale 1ns/1ps
`default_nettype none
`include "periph_ctrl_defines.vh"
module tb_analog_peripheral_control_regs;
    localparam logic [3:0] a_gd = `GATE_DRIVE_ENABLE_CTRL_ADDR;
    localparam logic [3:0] a_ab = `ANALOG_BLOCK_ENABLE_CTRL_ADDR;
    localparam logic [3:0] a_rl = `ROLE_AND_FEEDBACK_MUX_CTRL_ADDR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, overvoltage_protection_active = 1'b0;
    logic [6:0] src = 7'h00;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [7:0] w1[5] = '{8'h81, 8'h01, 8'h08, 8'h02, 8'h04};
    logic [7:0] r1[5] = '{8'h81, 8'h01, 8'h08, 8'h02, 8'h00};
    logic [4:0] p1[5] = '{5'h10, 5'h02, 5'h09, 5'h05, 5'h01};
    int n_errors = 0;
    int num_checks = 0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp, role_config;
    wire logic [31:0] s_axi_rdata;
    wire logic desat_comparator_out, pulse_after_monostable, oscillator_pwm, timer_period_match;
    wire logic overvoltage_comparator, switching_frequency_out, secondary_on_pulse;
    wire logic primary_gate_output_enable, secondary_gate_output_enable, primary_deadtime_bypass;
    wire logic secondary_deadtime_bypass, sense_pullup_enable, primary_steering_active;
    wire logic secondary_steering_active, shared_test_pin, shared_test_pin_oe, analog_test_to_pin;
    wire logic analog_test_to_converter, gate_uvlo_level_select, error_amp_disable;
    wire logic second_reference_to_gpio, feedback_path_select;
    wire logic [7:0] drv = {primary_gate_output_enable, secondary_gate_output_enable,
        primary_deadtime_bypass, secondary_deadtime_bypass, 1'b0, sense_pullup_enable,
        primary_steering_active, secondary_steering_active};
    wire logic [4:0] tst = {shared_test_pin_oe, gate_uvlo_level_select, error_amp_disable,
        analog_test_to_pin, analog_test_to_converter};
    assign {secondary_on_pulse, switching_frequency_out, overvoltage_comparator,
        timer_period_match, oscillator_pwm, pulse_after_monostable, desat_comparator_out} = src;
    analog_peripheral_control_regs uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .desat_comparator_out, .pulse_after_monostable,
        .oscillator_pwm, .timer_period_match, .overvoltage_comparator, .switching_frequency_out,
        .secondary_on_pulse, .overvoltage_protection_active, .primary_gate_output_enable,
        .secondary_gate_output_enable, .primary_deadtime_bypass, .secondary_deadtime_bypass,
        .sense_pullup_enable, .primary_steering_active, .secondary_steering_active,
        .shared_test_pin, .shared_test_pin_oe, .analog_test_to_pin, .analog_test_to_converter,
        .gate_uvlo_level_select, .error_amp_disable, .role_config, .second_reference_to_gpio,
        .feedback_path_select);
    always #50 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Both channels offered together; each released at the edge its ready is seen
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_read(input logic [3:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic wr_rd(input logic [3:0] a, input logic [31:0] w, input logic [31:0] e);
        axi_write(a, w, 4'hf);
        chk(32'(rr), 32'(`AXI_RESP_OKAY));
        axi_read(a);
        chk(rd, e);
    endtask
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(a_gd);
        chk(rd, 32'h4);
        chk(32'(drv), 32'h04);
        chk(32'(tst), 32'h01);
        $display("Reset values done");
        overvoltage_protection_active <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr_rd(a_gd, 32'h1 << i, (32'h1 << i) & 32'hf7);
            chk(32'(drv), (32'h1 << i) & 32'hf7);
        end
        wr_rd(a_gd, 32'h3, 32'h3);
        chk(32'(drv), 32'h02);
        overvoltage_protection_active <= 1'b0;
        wr_rd(a_gd, 32'hffff_ff01, 32'h1);
        chk(32'(drv), 32'h00);
        overvoltage_protection_active <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'(drv), 32'h01);
        $display("Gate drive register done");
        for (int k = 0; k < 5; k++) begin
            wr_rd(a_ab, 32'(w1[k]), 32'(r1[k]));
            chk(32'(tst), 32'(p1[k]));
        end
        // Sources are one-hot, then inverted, so a wrong code cannot pass
        for (int c = 0; c < 8; c++) begin
            src <= 7'h1 << c;
            wr_rd(a_ab, 32'h80 | (c << 4), 32'h80 | (c << 4));
            repeat (3) @(posedge aclk);
            chk(32'(shared_test_pin), 32'(c < 7));
            src <= ~(7'h1 << c);
            repeat (3) @(posedge aclk);
            chk(32'(shared_test_pin), 32'h0);
        end
        $display("Test pin routing done");
        for (int r = 0; r < 4; r++) begin
            wr_rd(a_rl, (r << 6) | ((r & 1) << 5) | 32'h1f, (r << 6) | ((r & 1) << 5));
            chk(32'({role_config, second_reference_to_gpio, feedback_path_select}),
                r * 4 + (r == 1) * 2 + (r & 1));
        end
        axi_write(4'hc, 32'hff, 4'hf);
        chk(32'(rr), 32'(`AXI_RESP_SLVERR));
        axi_read(4'hc);
        chk(32'(rr), 32'(`AXI_RESP_SLVERR));
        chk(rd, 32'h0);
        axi_write(a_gd, 32'h0, 4'h0);
        axi_read(a_gd);
        chk(rd, 32'h1);
        $display("Access errors done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(a_gd);
        chk(rd, 32'h4);
        axi_read(a_rl);
        chk(rd, 32'h0);
        $display("Second reset done");
        wrap_up;
    end
endmodule
`default_nettype wire
